// [inc/led_pkg.sv]
// What this block does
// - Three indicator outputs per port.
// - Strap picks mode one/two; register picks three.
// - Strapped pin level sets output polarity.
// - Mode one: link light follows link good.
// - Modes two/three: link on, blinks on activity.
// - Speed light on at 100, all modes.
// - Mode one: shared light shows activity.
// - Mode two: shared light shows collision.
// - Mode three: shared light may show duplex.
// - Straps latched after reset, then held.
package led_pkg;
    // Timing
    localparam int CLK_HZ            = 20_000_000;
    localparam int BLINK_HALF_MS     = 50;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
    // Cycles after reset release before straps are sampled
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // Structure
    localparam int PORTS = 2;
    localparam int LEDS  = 3;
    localparam int LED_LINK   = 0;
    localparam int LED_SPEED  = 1;
    localparam int LED_ACTCOL = 2;

    // Register map, byte addresses
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

    // Control fields
    localparam int CTRL_MODE3_BIT  = 0;
    localparam int CTRL_DUPLEX_LSB = 1;

    // Status fields
    localparam int ST_DONE_BIT  = 0;
    localparam int ST_MODE_BIT  = 1;
    localparam int ST_STRAP_LSB = 2;
    localparam int ST_LED_LSB   = 8;
    localparam int ST_MODE3_BIT = 14;

    // Strap level on the mode pin that selects mode one
    localparam logic MODE_STRAP_ONE = 1'b1;

    typedef enum logic [1:0] {
        MODE_ONE   = 2'b00,
        MODE_TWO   = 2'b01,
        MODE_THREE = 2'b10
    } led_mode_type;
endpackage

// [rtl/led_port.sv]
`timescale 1ns/100ps
`default_nettype none
module led_port #(
    parameter int unsigned HALF = led_pkg::BLINK_HALF_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire led_pkg::led_mode_type mode,
    input  wire logic                 duplex_sel,
    input  wire logic                 strap_done,
    input  wire logic [2:0]           polarity,
    input  wire logic                 link,
    input  wire logic                 speed,
    input  wire logic                 duplex,
    input  wire logic                 tx_act,
    input  wire logic                 rx_act,
    input  wire logic                 col,
    output logic      [2:0]           led
);
    localparam int unsigned CNT_W = $clog2(2 * HALF + 1);
    localparam logic [CNT_W-1:0] HALF_C = CNT_W'(HALF);
    localparam logic [CNT_W-1:0] LAST_C = CNT_W'(2 * HALF - 1);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             blinking;
        logic             prev_act;
        logic [2:0]       led;
    } port_state_type;

    port_state_type state;
    port_state_type next_state;
    logic           activity;
    logic           blink_off;
    logic [2:0]     on;

    // Next state of blink timer and lights
    always_comb begin
        next_state = state;
        activity   = tx_act | rx_act;
        if (activity && (!state.prev_act || !state.blinking)) begin
            next_state.count    = '0;
            next_state.blinking = 1'b1;
        end else if (state.blinking) begin
            if (state.count == LAST_C) begin
                next_state.blinking = 1'b0;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
        next_state.prev_act = activity;
        // First half of each period is dark
        blink_off = state.blinking && (state.count < HALF_C);
        on        = 3'h0;
        on[led_pkg::LED_SPEED] = speed;
        unique case (mode)
            led_pkg::MODE_ONE: begin
                on[led_pkg::LED_LINK]   = link;
                on[led_pkg::LED_ACTCOL] = activity;
            end
            led_pkg::MODE_TWO: begin
                on[led_pkg::LED_LINK]   = link && !blink_off;
                on[led_pkg::LED_ACTCOL] = col;
            end
            led_pkg::MODE_THREE: begin
                on[led_pkg::LED_LINK]   = link && !blink_off;
                on[led_pkg::LED_ACTCOL] = duplex_sel ? duplex : col;
            end
            default: begin
                on = 3'h0; // Unused mode code keeps lights dark
            end
        endcase
        // drive opposite to the strap pull
        next_state.led = strap_done ? (on ^ polarity) : polarity;
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign led = state.led;
endmodule // led_port
`default_nettype wire

// [rtl/phy_status_led_driver.sv]
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module phy_status_led_driver #(
    parameter int unsigned BLINK_HALF = led_pkg::BLINK_HALF_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Mode strap pin, sampled after reset
    input  wire logic        LED_MODE_STRAP,
    // Transceiver core indications, port A
    input  wire logic        LINK_GOOD_A,
    input  wire logic        SPEED_100_A,
    input  wire logic        FULL_DUPLEX_A,
    input  wire logic        TX_ACTIVE_A,
    input  wire logic        RX_ACTIVE_A,
    input  wire logic        COLLISION_A,
    // Transceiver core indications, port B
    input  wire logic        LINK_GOOD_B,
    input  wire logic        SPEED_100_B,
    input  wire logic        FULL_DUPLEX_B,
    input  wire logic        TX_ACTIVE_B,
    input  wire logic        RX_ACTIVE_B,
    input  wire logic        COLLISION_B,
    // Indicator pins, port A
    input  wire logic        LINK_INDICATOR_PORT_A_IN,
    output logic             LINK_INDICATOR_PORT_A_OUT,
    output logic             LINK_INDICATOR_PORT_A_OE_N,
    input  wire logic        SPEED_INDICATOR_PORT_A_IN,
    output logic             SPEED_INDICATOR_PORT_A_OUT,
    output logic             SPEED_INDICATOR_PORT_A_OE_N,
    input  wire logic        ACTIVITY_COLLISION_INDICATOR_PORT_A_IN,
    output logic             ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT,
    output logic             ACTIVITY_COLLISION_INDICATOR_PORT_A_OE_N,
    // Indicator pins, port B
    input  wire logic        LINK_INDICATOR_PORT_B_IN,
    output logic             LINK_INDICATOR_PORT_B_OUT,
    output logic             LINK_INDICATOR_PORT_B_OE_N,
    input  wire logic        SPEED_INDICATOR_PORT_B_IN,
    output logic             SPEED_INDICATOR_PORT_B_OUT,
    output logic             SPEED_INDICATOR_PORT_B_OE_N,
    input  wire logic        ACTIVITY_COLLISION_INDICATOR_PORT_B_IN,
    output logic             ACTIVITY_COLLISION_INDICATOR_PORT_B_OUT,
    output logic             ACTIVITY_COLLISION_INDICATOR_PORT_B_OE_N
);
    localparam int PINS = led_pkg::PORTS * led_pkg::LEDS;

    typedef struct packed {
        logic [PINS-1:0]          pin_meta;
        logic [PINS-1:0]          pin_sync;
        logic                     mode_meta;
        logic                     mode_sync;
        logic [1:0]               wait_cnt;
        logic                     strap_done;
        logic [PINS-1:0]          strap_pin;
        logic                     strap_mode;
        logic                     mode3;
        logic [led_pkg::PORTS-1:0] dup_sel;
        logic [31:0]              prdata;
    } top_state_type;

    top_state_type state;
    top_state_type next_state;

    logic [1:0]      rst_pipe;
    logic            rst_n;
    logic [PINS-1:0] pin_in;
    logic [PINS-1:0] led_level;
    logic            setup;
    logic            access;
    logic            hit_ctrl;
    logic            hit_status;
    logic [31:0]     ctrl_word;
    logic [31:0]     status_word;
    led_pkg::led_mode_type mode;

    logic [led_pkg::PORTS-1:0] link;
    logic [led_pkg::PORTS-1:0] speed;
    logic [led_pkg::PORTS-1:0] duplex;
    logic [led_pkg::PORTS-1:0] tx_act;
    logic [led_pkg::PORTS-1:0] rx_act;
    logic [led_pkg::PORTS-1:0] col;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Gather pins, port A in the low three bits
    assign pin_in = {ACTIVITY_COLLISION_INDICATOR_PORT_B_IN,
                     SPEED_INDICATOR_PORT_B_IN,
                     LINK_INDICATOR_PORT_B_IN,
                     ACTIVITY_COLLISION_INDICATOR_PORT_A_IN,
                     SPEED_INDICATOR_PORT_A_IN,
                     LINK_INDICATOR_PORT_A_IN};

    // Core indications, same clock, no synchroniser
    assign link   = {LINK_GOOD_B, LINK_GOOD_A};
    assign speed  = {SPEED_100_B, SPEED_100_A};
    assign duplex = {FULL_DUPLEX_B, FULL_DUPLEX_A};
    assign tx_act = {TX_ACTIVE_B, TX_ACTIVE_A};
    assign rx_act = {RX_ACTIVE_B, RX_ACTIVE_A};
    assign col    = {COLLISION_B, COLLISION_A};

    // APB phase and address decode
    assign setup      = PSEL && !PENABLE;
    assign access     = PSEL && PENABLE;
    assign hit_ctrl   = (PADDR == led_pkg::CTRL_OFFSET);
    assign hit_status = (PADDR == led_pkg::STATUS_OFFSET);

    // Control readback
    always_comb begin
        ctrl_word = led_pkg::CTRL_RESET;
        ctrl_word[led_pkg::CTRL_MODE3_BIT] = state.mode3;
        ctrl_word[led_pkg::CTRL_DUPLEX_LSB +: led_pkg::PORTS] = state.dup_sel;
    end

    // Status shows straps and the live lights
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[led_pkg::ST_DONE_BIT] = state.strap_done;
        status_word[led_pkg::ST_MODE_BIT] = state.strap_mode;
        status_word[led_pkg::ST_STRAP_LSB +: PINS] = state.strap_pin;
        status_word[led_pkg::ST_LED_LSB +: PINS] = led_level;
        status_word[led_pkg::ST_MODE3_BIT] = (mode == led_pkg::MODE_THREE);
    end

    always_comb begin
        if (state.mode3) begin
            mode = led_pkg::MODE_THREE;
        end else if (state.strap_mode == led_pkg::MODE_STRAP_ONE) begin
            mode = led_pkg::MODE_ONE;
        end else begin
            mode = led_pkg::MODE_TWO;
        end
    end

    // Next state: synchronisers, strap capture, registers
    always_comb begin
        next_state = state;
        // Two-flop synchronisers on the pins
        next_state.pin_meta  = pin_in;
        next_state.pin_sync  = state.pin_meta;
        next_state.mode_meta = LED_MODE_STRAP;
        next_state.mode_sync = state.mode_meta;
        // latch straps once the synchronisers hold pin levels
        if (!state.strap_done) begin
            if (state.wait_cnt == led_pkg::STRAP_WAIT) begin
                next_state.strap_done = 1'b1;
                next_state.strap_pin  = state.pin_sync;
                next_state.strap_mode = state.mode_sync;
            end else begin
                next_state.wait_cnt = state.wait_cnt + 2'h1;
            end
        end
        // Read data prepared in the setup phase
        if (setup && !PWRITE) begin
            if (hit_ctrl) begin
                next_state.prdata = ctrl_word;
            end else if (hit_status) begin
                next_state.prdata = status_word;
            end else begin
                next_state.prdata = 32'h0000_0000;
            end
        end
        if (access && PWRITE && hit_ctrl && PSTRB[0]) begin
            next_state.mode3   = PWDATA[led_pkg::CTRL_MODE3_BIT];
            next_state.dup_sel = PWDATA[led_pkg::CTRL_DUPLEX_LSB +: led_pkg::PORTS];
        end
    end

    // State register, frozen while CE is low
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else if (CE) begin
            state <= next_state;
        end
    end

    // Zero wait states; a frozen block stretches the access
    assign PREADY  = CE;
    assign PSLVERR = access && !(hit_ctrl || (hit_status && !PWRITE));
    assign PRDATA  = state.prdata;

    generate
        for (genvar p = 0; p < led_pkg::PORTS; p++) begin : g_port
            led_port #(
                .HALF(BLINK_HALF)
            ) u_port (
                .clk        (CLK),
                .rst_n      (rst_n),
                .ce         (CE),
                .mode       (mode),
                .duplex_sel (state.dup_sel[p]),
                .strap_done (state.strap_done),
                .polarity   (state.strap_pin[p*led_pkg::LEDS +: led_pkg::LEDS]),
                .link       (link[p]),
                .speed      (speed[p]),
                .duplex     (duplex[p]),
                .tx_act     (tx_act[p]),
                .rx_act     (rx_act[p]),
                .col        (col[p]),
                .led        (led_level[p*led_pkg::LEDS +: led_pkg::LEDS])
            );
        end
    endgenerate

    assign LINK_INDICATOR_PORT_A_OUT               = led_level[0];
    assign SPEED_INDICATOR_PORT_A_OUT              = led_level[1];
    assign ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT = led_level[2];
    assign LINK_INDICATOR_PORT_B_OUT               = led_level[3];
    assign SPEED_INDICATOR_PORT_B_OUT              = led_level[4];
    assign ACTIVITY_COLLISION_INDICATOR_PORT_B_OUT = led_level[5];

    // Pins float until straps are caught so the pulls are readable
    assign LINK_INDICATOR_PORT_A_OE_N               = !state.strap_done;
    assign SPEED_INDICATOR_PORT_A_OE_N              = !state.strap_done;
    assign ACTIVITY_COLLISION_INDICATOR_PORT_A_OE_N = !state.strap_done;
    assign LINK_INDICATOR_PORT_B_OE_N               = !state.strap_done;
    assign SPEED_INDICATOR_PORT_B_OE_N              = !state.strap_done;
    assign ACTIVITY_COLLISION_INDICATOR_PORT_B_OE_N = !state.strap_done;
endmodule // phy_status_led_driver
`default_nettype wire

// [verification/led_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
module led_pins_model (
    input  wire logic [6:0] pull,
    input  wire logic [5:0] out,
    input  wire logic [5:0] oe_n,
    output logic      [6:0] pin
);
    // pull sets strap
    // A released pin rests at its resistor level, so a weak driver is never masked
    always_comb begin
        pin[6] = pull[6];
        for (int i = 0; i < 6; i++) begin
            pin[i] = oe_n[i] ? pull[i] : out[i];
        end
    end
endmodule // led_pins_model
`default_nettype wire

// [verification/phy_status_led_driver_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module led_checker #(
    parameter int unsigned BLINK_HALF = 4
) (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        CE,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic        PREADY,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic        LED_MODE_STRAP,
    input wire logic        LINK_GOOD_A,
    input wire logic        SPEED_100_A,
    input wire logic        FULL_DUPLEX_A,
    input wire logic        TX_ACTIVE_A,
    input wire logic        RX_ACTIVE_A,
    input wire logic        COLLISION_A,
    input wire logic        LINK_INDICATOR_PORT_A_IN,
    input wire logic        LINK_INDICATOR_PORT_A_OUT,
    input wire logic        LINK_INDICATOR_PORT_A_OE_N,
    input wire logic        SPEED_INDICATOR_PORT_A_IN,
    input wire logic        SPEED_INDICATOR_PORT_A_OUT,
    input wire logic        ACTIVITY_COLLISION_INDICATOR_PORT_A_IN,
    input wire logic        ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT
);
    logic       sm, sl, ss, sa, go, ce1;
    logic [1:0] c, c1, c2;
    // Strap copies taken only while the pins are released
    always_ff @(posedge CLK) begin
        if (LINK_INDICATOR_PORT_A_OE_N) begin
            sm <= LED_MODE_STRAP;
            sl <= LINK_INDICATOR_PORT_A_IN;
            ss <= SPEED_INDICATOR_PORT_A_IN;
            sa <= ACTIVITY_COLLISION_INDICATOR_PORT_A_IN;
        end
    end
    // Control mirror; delayed copies hide the mode change latency
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            c  <= 2'h0;
            c1 <= 2'h0;
            c2 <= 2'h0;
            go <= 1'b0;
            ce1 <= 1'b0;
        end else begin
            ce1 <= CE; // Lights only moved at an enabled edge
            if (PSEL && PENABLE && PWRITE && PREADY && PADDR == led_pkg::CTRL_OFFSET && PSTRB[0])
                c <= PWDATA[1:0];
            c1 <= c;
            c2 <= c1;
            go <= !LINK_INDICATOR_PORT_A_OE_N;
        end
    end
    wire logic ok  = go && ce1 && !LINK_INDICATOR_PORT_A_OE_N && c == c1 && c1 == c2;
    wire logic m1  = !c[0] && sm == led_pkg::MODE_STRAP_ONE;
    wire logic act = TX_ACTIVE_A || RX_ACTIVE_A;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    a_speed_follows: assert property (
        ok |-> SPEED_INDICATOR_PORT_A_OUT == ($past(SPEED_100_A) ^ ss))
        else $error("speed light wrong");
    a_link_mode_one: assert property (
        ok && m1 |-> LINK_INDICATOR_PORT_A_OUT == ($past(LINK_GOOD_A) ^ sl))
        else $error("link light wrong in mode one");
    a_act_mode_one: assert property (
        ok && m1 |-> ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT == ($past(act) ^ sa))
        else $error("activity light wrong");
    a_col_mode_two: assert property (
        ok && !c[0] && !m1 |-> ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT == ($past(COLLISION_A) ^ sa))
        else $error("collision light wrong");
    a_duplex_mode_three: assert property (
        ok && c == 2'h3 |-> ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT == ($past(FULL_DUPLEX_A) ^ sa))
        else $error("duplex light wrong");
    a_link_down_off: assert property (
        ok && !m1 && !$past(LINK_GOOD_A) |-> LINK_INDICATOR_PORT_A_OUT == sl)
        else $error("link light lit without link");
    a_blink_dark_start: assert property (
        ok && !m1 && $rose(act) |-> ##3 (LINK_INDICATOR_PORT_A_OUT == sl)[*2])
        else $error("no dark phase after activity");
    a_straps_held: assert property (
        !LINK_INDICATOR_PORT_A_OE_N |=> !LINK_INDICATOR_PORT_A_OE_N)
        else $error("pin released after latch");
endmodule // led_checker
bind phy_status_led_driver led_checker #(.BLINK_HALF(BLINK_HALF)) u_chk (.*);
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        CE = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [3:0]  PSTRB = 4'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [5:0]  ca = 6'h00;
    logic [5:0]  cb = 6'h00;
    logic [6:0]  pull = 7'h00;
    wire  logic [5:0] po;
    wire  logic [5:0] pe;
    wire  logic [6:0] pin;
    wire  logic  LED_MODE_STRAP = pin[6];
    int          num_errors = 0;
    int          total_checks = 0;
    logic [31:0] rd;
    logic        er;
    // Core bits: link, speed, duplex, tx, rx, collision; pins A then B
    phy_status_led_driver #(.BLINK_HALF(4)) dut (.*,
        .LINK_GOOD_A(ca[0]), .SPEED_100_A(ca[1]), .FULL_DUPLEX_A(ca[2]),
        .TX_ACTIVE_A(ca[3]), .RX_ACTIVE_A(ca[4]), .COLLISION_A(ca[5]),
        .LINK_GOOD_B(cb[0]), .SPEED_100_B(cb[1]), .FULL_DUPLEX_B(cb[2]),
        .TX_ACTIVE_B(cb[3]), .RX_ACTIVE_B(cb[4]), .COLLISION_B(cb[5]),
        .LINK_INDICATOR_PORT_A_IN(pin[0]), .LINK_INDICATOR_PORT_A_OUT(po[0]),
        .LINK_INDICATOR_PORT_A_OE_N(pe[0]), .SPEED_INDICATOR_PORT_A_IN(pin[1]),
        .SPEED_INDICATOR_PORT_A_OUT(po[1]), .SPEED_INDICATOR_PORT_A_OE_N(pe[1]),
        .ACTIVITY_COLLISION_INDICATOR_PORT_A_IN(pin[2]),
        .ACTIVITY_COLLISION_INDICATOR_PORT_A_OUT(po[2]),
        .ACTIVITY_COLLISION_INDICATOR_PORT_A_OE_N(pe[2]),
        .LINK_INDICATOR_PORT_B_IN(pin[3]), .LINK_INDICATOR_PORT_B_OUT(po[3]),
        .LINK_INDICATOR_PORT_B_OE_N(pe[3]), .SPEED_INDICATOR_PORT_B_IN(pin[4]),
        .SPEED_INDICATOR_PORT_B_OUT(po[4]), .SPEED_INDICATOR_PORT_B_OE_N(pe[4]),
        .ACTIVITY_COLLISION_INDICATOR_PORT_B_IN(pin[5]),
        .ACTIVITY_COLLISION_INDICATOR_PORT_B_OUT(po[5]),
        .ACTIVITY_COLLISION_INDICATOR_PORT_B_OE_N(pe[5]));
    led_pins_model leds (.pull(pull), .out(po), .oe_n(pe), .pin(pin));
    // 20 MHz clock
    initial begin
        forever #25 CLK = ~CLK;
    end
    // Hang guard, far beyond the roughly 120 cycles the run needs
    initial begin
        #200_000;
        num_errors++;
        final_report();
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge CLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        PSTRB   <= s;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // Reset with new strap pulls, then confirm what was latched
    task automatic boot(input logic [6:0] p);
        // Reset and pulls change only just after a rising edge
        @(posedge CLK);
        RESET_N <= 1'b0;
        pull    <= p;
        ca      <= 6'h00;
        cb      <= 6'h00;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (14) @(posedge CLK);
        chk("oe_n", {26'h0, pe}, 32'h0);
        apb(1'b0, led_pkg::STATUS_OFFSET, 32'h0, 4'h0, rd, er);
        chk("status", {17'h0, rd[14:0]}, {18'h0, p[5:0], p[5:0], p[6], 1'b1});
    endtask
    // Drive both cores, then compare the pins; lit means opposite to the pull
    task automatic look(input logic [5:0] a, input logic [5:0] b, input logic [5:0] on);
        @(posedge CLK);
        ca <= a;
        cb <= b;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk("leds", {26'h0, pin[5:0]}, {26'h0, on ^ pull[5:0]});
    endtask
    task automatic t_mode_one();
        boot(7'h47);
        look(6'h0b, 6'h00, 6'h07);
        look(6'h32, 6'h11, 6'h2e);
        look(6'h24, 6'h02, 6'h10);
    endtask
    task automatic t_mode_two();
        boot(7'h38);
        look(6'h21, 6'h01, 6'h0d);
        // Single activity pulse: dark phase, then steady again
        @(posedge CLK);
        ca <= 6'h09;
        @(posedge CLK);
        ca <= 6'h01;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        chk("blink dark", {31'h0, pin[0]}, {31'h0, pull[0]});
        repeat (4) @(posedge CLK);
        @(negedge CLK);
        chk("blink lit", {31'h0, pin[0]}, {31'h0, ~pull[0]});
        look(6'h08, 6'h00, 6'h00);
        // Mode pin flipped after latch must change nothing
        @(posedge CLK);
        pull <= 7'h78;
        look(6'h20, 6'h00, 6'h04);
    endtask
    task automatic t_mode_three();
        apb(1'b1, led_pkg::CTRL_OFFSET, 32'h3, 4'h1, rd, er);
        look(6'h25, 6'h21, 6'h2d);
        look(6'h21, 6'h05, 6'h09);
        apb(1'b1, led_pkg::CTRL_OFFSET, 32'h0, 4'h0, rd, er);
        apb(1'b0, led_pkg::CTRL_OFFSET, 32'h0, 4'h0, rd, er);
        chk("ctrl", rd, 32'h3);
        apb(1'b0, led_pkg::STATUS_OFFSET, 32'h0, 4'h0, rd, er);
        chk("mode three", {31'h0, rd[14]}, 32'h1);
        apb(1'b0, 8'h08, 32'h0, 4'h0, rd, er);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, led_pkg::STATUS_OFFSET, 32'h0, 4'hf, rd, er);
        chk("status write", {31'h0, er}, 32'h1);
        apb(1'b1, led_pkg::CTRL_OFFSET, 32'h1, 4'h1, rd, er);
        look(6'h21, 6'h00, 6'h05);
    endtask
    // Clock enable low: lights hold and the bus stalls until it returns
    task automatic t_clock_enable();
        @(posedge CLK);
        CE <= 1'b0;
        ca <= 6'h02;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        chk("frozen", {25'h0, PREADY, pin[5:0]}, {26'h0, 6'h05 ^ pull[5:0]});
        @(posedge CLK);
        CE <= 1'b1;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        chk("thawed", {26'h0, pin[5:0]}, {26'h0, 6'h02 ^ pull[5:0]});
    endtask
    initial begin
        t_mode_one();
        t_mode_two();
        t_mode_three();
        t_clock_enable();
        final_report();
    end
endmodule // testbench
`default_nettype wire
